//--- src/wdfc_pkg.sv
package wdfc_pkg;

  // register word indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'hA7;
  localparam logic [7:0] IDX_RELOAD = 8'hA8;
  localparam logic [7:0] IDX_FEED1 = 8'hA9;
  localparam logic [7:0] IDX_FEED2 = 8'hAA;
  localparam logic [7:0] IDX_STATUS = 8'hAB;
  localparam logic [7:0] IDX_MASK = 8'hAC;
  localparam logic [7:0] IDX_CFG = 8'hAD;
  localparam logic [7:0] IDX_COUNT = 8'hAE;

  // feed keys
  localparam logic [7:0] FEED1_KEY = 8'hA5;
  localparam logic [7:0] FEED2_KEY = 8'h5A;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'hE5;
  localparam logic [7:0] RELOAD_RESET = 8'hFF;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // prescaler: tap period is the base shifted left by the tap select
  localparam int unsigned PRESC_W = 13;
  localparam logic [PRESC_W-1:0] PRESC_BASE = 13'h0020;

  // status bit positions
  localparam int unsigned STAT_UNDERFLOW = 0;
  localparam int unsigned STAT_BADFEED = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout, bit 7 first
  typedef struct packed {
    logic [2:0] prescale_tap;
    logic [1:0] rsvd;
    logic run_control;
    logic timeout_flag;
    logic clock_select;
  } wdfc_ctrl_t;

  // fuse-like configuration bits
  typedef struct packed {
    logic safety_enable_cfg;
    logic reset_enable_cfg;
  } wdfc_cfg_t;

  typedef enum logic [1:0] {
    FEED_IDLE = 2'b01,
    FEED_ARMED = 2'b10
  } wdfc_feed_t;

endpackage : wdfc_pkg

//--- src/wdfc_watchdog.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module wdfc_watchdog (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output wdfc_pkg::wdfc_ctrl_t active_ctrl,
  output logic clock_select,
  output logic wdt_reset,
  output logic irq
);
  import wdfc_pkg::*;

  // returns {hit, index}; only the register words inside the map hit
  function automatic logic [8:0] decode(input logic [31:0] addr);
    logic hit;
    hit = (addr[31:10] == 22'h0) && (addr[1:0] == 2'h0) &&
          (addr[9:2] >= IDX_CONTROL) && (addr[9:2] <= IDX_COUNT);
    return {hit, addr[9:2]};
  endfunction : decode

  // bus slave state
  logic aw_full_q, aw_full_d;
  logic [31:0] awaddr_q, awaddr_d;
  logic w_full_q, w_full_d;
  logic [7:0] wdata_q, wdata_d;
  logic wlane_q, wlane_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic wr_fire;
  logic [8:0] wr_dec;
  logic [8:0] rd_dec;

  // watchdog state
  wdfc_ctrl_t staged_q, staged_d;
  wdfc_ctrl_t act_q, act_d;
  wdfc_cfg_t cfg_q, cfg_d;
  wdfc_feed_t feed_q, feed_d;
  logic [7:0] reload_q, reload_d;
  logic [7:0] cnt_q, cnt_d;
  logic [PRESC_W-1:0] presc_q, presc_d;
  logic ctrl_pend_q, ctrl_pend_d;
  logic ctrl_once_q, ctrl_once_d;
  logic reload_once_q, reload_once_d;
  logic [1:0] status_q, status_d;
  logic [1:0] mask_q, mask_d;
  logic reset_q, reset_d;
  logic wr_en;
  logic [7:0] wr_idx;
  logic wd_mode;
  logic safety;
  logic feed_ok;
  logic bad_feed;
  logic underflow;
  logic flag_clr;
  logic [PRESC_W-1:0] tap_limit;

  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_dec = decode(awaddr_q);
  assign rd_dec = decode(s_axi_araddr);
  assign wr_en = wr_fire && wlane_q && wr_dec[8];
  assign wr_idx = wr_dec[7:0];
  assign wd_mode = cfg_q.reset_enable_cfg;
  assign safety = cfg_q.reset_enable_cfg && cfg_q.safety_enable_cfg;

  // handshake outputs straight from holding state
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {24'h00_0000, rdata_q};
  assign active_ctrl = act_q;
  assign clock_select = act_q.clock_select;
  assign wdt_reset = reset_q;
  assign irq = |(status_q & mask_q);

  // bus slave: address and data are held separately, write runs when both are in
  always_comb begin
    aw_full_d = aw_full_q;
    awaddr_d = awaddr_q;
    w_full_d = w_full_q;
    wdata_d = wdata_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && !aw_full_q) begin
      aw_full_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_q) begin
      w_full_d = 1'b1;
      wdata_d = s_axi_wdata[7:0];
      wlane_d = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_dec[8] ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    // reads have no side effect, so they never disturb a feed
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = rd_dec[8] ? RESP_OKAY : RESP_SLVERR;
      case (rd_dec[7:0])
        IDX_CONTROL: rdata_d = {act_q.prescale_tap, 2'h0, act_q.run_control,
                                act_q.timeout_flag, act_q.clock_select};
        IDX_RELOAD: rdata_d = reload_q;
        IDX_STATUS: rdata_d = {6'h00, status_q};
        IDX_MASK: rdata_d = {6'h00, mask_q};
        IDX_CFG: rdata_d = {6'h00, cfg_q};
        IDX_COUNT: rdata_d = cnt_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      w_full_q <= 1'b0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      awaddr_q <= awaddr_d;
      w_full_q <= w_full_d;
      wdata_q <= wdata_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // feed sequencer, staged registers, down counter and flags
  always_comb begin
    feed_d = feed_q;
    ctrl_pend_d = ctrl_pend_q;
    ctrl_once_d = ctrl_once_q;
    reload_once_d = reload_once_q;
    staged_d = staged_q;
    reload_d = reload_q;
    cfg_d = cfg_q;
    mask_d = mask_q;
    status_d = status_q;
    act_d = act_q;
    cnt_d = cnt_q;
    presc_d = presc_q;
    feed_ok = 1'b0;
    bad_feed = 1'b0;
    underflow = 1'b0;
    flag_clr = 1'b0;
    tap_limit = (PRESC_BASE << act_q.prescale_tap) - 13'h0001;
    if (wr_en) begin
      case (wr_idx)
        IDX_FEED1: begin
          if (wdata_q == FEED1_KEY && feed_q == FEED_IDLE) begin
            feed_d = FEED_ARMED;
          end else begin
            bad_feed = 1'b1;
            feed_d = FEED_IDLE;
          end
        end
        IDX_FEED2: begin
          feed_d = FEED_IDLE;
          if (feed_q == FEED_ARMED && wdata_q == FEED2_KEY) begin
            feed_ok = 1'b1;
          end else begin
            bad_feed = 1'b1;
          end
        end
        default: begin
          // any other write breaks an armed feed or an owed feed
          bad_feed = (feed_q == FEED_ARMED) || ctrl_pend_q;
          feed_d = FEED_IDLE;
        end
      endcase
      case (wr_idx)
        IDX_CONTROL: begin
          if (!(safety && ctrl_once_q)) begin
            staged_d = wdata_q;
            staged_d.rsvd = 2'h0;
            ctrl_once_d = safety; // only writes made under safety use up the one write
            ctrl_pend_d = wd_mode;
            flag_clr = !wdata_q[1];
          end
        end
        IDX_RELOAD: begin
          if (!(safety && reload_once_q)) begin
            reload_d = wdata_q;
            reload_once_d = safety;
          end
        end
        IDX_STATUS: status_d = status_q & ~wdata_q[1:0];
        IDX_MASK: mask_d = wdata_q[1:0];
        // once safety is set the configuration is locked like a fuse
        IDX_CFG: cfg_d = safety ? cfg_q : wdfc_cfg_t'(wdata_q[1:0]);
        default: begin
        end
      endcase
    end
    if (feed_ok || bad_feed) begin
      ctrl_pend_d = 1'b0;
    end
    // timer mode tracks the staged value, watchdog mode waits for a feed
    if (!wd_mode || feed_ok) begin
      act_d.prescale_tap = staged_q.prescale_tap;
      act_d.run_control = staged_q.run_control;
      act_d.clock_select = staged_q.clock_select;
    end
    act_d.rsvd = 2'h0;
    if (safety) begin
      act_d.clock_select = 1'b1;
      act_d.run_control = 1'b1;
    end
    // counter: a feed parks the prescaler one below zero, the extra clock of the first period
    if (feed_ok) begin
      cnt_d = reload_q;
      presc_d = {PRESC_W{1'b1}};
    end else if (act_q.run_control) begin
      if (presc_q >= tap_limit && presc_q != {PRESC_W{1'b1}}) begin
        presc_d = {PRESC_W{1'b0}};
        if (cnt_q == 8'h00) begin
          underflow = 1'b1;
          cnt_d = reload_q;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end else begin
        presc_d = presc_q + 13'h0001;
      end
    end
    // the flag: set wins over any clear in the same cycle
    if (flag_clr || (feed_ok && wd_mode)) begin
      act_d.timeout_flag = 1'b0;
    end
    if (underflow) begin
      act_d.timeout_flag = 1'b1;
      status_d[STAT_UNDERFLOW] = 1'b1;
    end
    if (bad_feed && wd_mode) begin
      status_d[STAT_BADFEED] = 1'b1;
    end
    // timer mode drops bad feeds without any reset
    reset_d = wd_mode && (bad_feed || underflow);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      feed_q <= FEED_IDLE;
      ctrl_pend_q <= 1'b0;
      ctrl_once_q <= 1'b0;
      reload_once_q <= 1'b0;
      staged_q <= CTRL_RESET;
      act_q <= CTRL_RESET;
      reload_q <= RELOAD_RESET;
      cnt_q <= RELOAD_RESET;
      presc_q <= {PRESC_W{1'b0}};
      cfg_q <= CFG_RESET;
      status_q <= STAT_RESET;
      mask_q <= MASK_RESET;
      reset_q <= 1'b0;
    end else begin
      feed_q <= feed_d;
      ctrl_pend_q <= ctrl_pend_d;
      ctrl_once_q <= ctrl_once_d;
      reload_once_q <= reload_once_d;
      staged_q <= staged_d;
      act_q <= act_d;
      reload_q <= reload_d;
      cnt_q <= cnt_d;
      presc_q <= presc_d;
      cfg_q <= cfg_d;
      status_q <= status_d;
      mask_q <= mask_d;
      reset_q <= reset_d;
    end
  end

endmodule : wdfc_watchdog

//--- test/wdfc_watchdog_asserts.sv
`timescale 1ns/1ps
module wdfc_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire wdfc_pkg::wdfc_ctrl_t active_ctrl,
  input wire logic clock_select
);
  import wdfc_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // one transfer at a time, so an answer never repeats right after its handshake
  chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_r_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  // answer latency after a request is taken
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address ready again before the write ran");
  // active control layout as seen on the port
  chk_clksel_mirror: assert property (clock_select == active_ctrl.clock_select)
    else $error("clock select differs from control");
  chk_rsvd_zero: assert property (active_ctrl.rsvd == 2'h0)
    else $error("reserved control bits set");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_SLVERR);
  cover property ($rose(active_ctrl.timeout_flag));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : wdfc_chk

//--- test/test_watchdog_feed_and_control.sv
`timescale 1ns/1ps
module test_watchdog_feed_and_control;
  import wdfc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, clock_select, wdt_reset, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wdfc_ctrl_t active_ctrl;
  int bad_count = 0;
  int check_count = 0;
  int rst_seen = 0;
  int cyc = 0;
  // answers are always accepted at once
  always #12.5 ref_clk = ~ref_clk;
  wdfc_watchdog DUT (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .active_ctrl, .clock_select, .wdt_reset, .irq);
  // count reset pulses; cut a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (wdt_reset === 1'b1) rst_seen <= rst_seen + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      results();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // values read just after an edge are those that edge sampled
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        a = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd
  task automatic feed();
    logic [1:0] r;
    wr(IDX_FEED1, FEED1_KEY, r);
    wr(IDX_FEED2, FEED2_KEY, r);
  endtask : feed
  task automatic t_reset_bus();
    logic [31:0] d;
    logic [1:0] r;
    check("ctrl port", active_ctrl, CTRL_RESET);
    rd(IDX_CONTROL, d, r);
    check("ctrl read", d, {24'h0, CTRL_RESET});
    rd(8'hAF, d, r);
    check("unmapped rresp", r, RESP_SLVERR);
    check("unmapped rdata", d, 32'h0);
    wr(8'hAF, 8'h00, r);
    check("unmapped bresp", r, RESP_SLVERR);
  endtask : t_reset_bus
  task automatic t_timer();
    logic [1:0] r;
    int n;
    wr(IDX_RELOAD, 8'h00, r);
    wr(IDX_FEED1, 8'h00, r);
    repeat (3) @(posedge ref_clk);
    check("timer bad feed", rst_seen, 0);
    for (int t = 0; t < 3; t++) begin
      wr(IDX_CONTROL, {t[2:0], 5'h04}, r);
      @(posedge ref_clk);
      check("ctrl copy", active_ctrl, {t[2:0], 5'h04});
      feed();
      n = 0;
      while (active_ctrl.timeout_flag !== 1'b1 && n < 999) begin
        @(posedge ref_clk);
        n++;
      end
      check("timeout clocks", n, (32 << t) + 1);
    end
    // stop first so the status bit cannot come back during the irq checks
    wr(IDX_CONTROL, 8'h00, r);
    @(posedge ref_clk);
    check("flag clear", active_ctrl, 8'h00);
    wr(IDX_MASK, 8'h01, r);
    check("irq set", irq, 1'b1);
    wr(IDX_STATUS, 8'h01, r);
    check("irq clear", irq, 1'b0);
  endtask : t_timer
  task automatic t_watchdog();
    logic [7:0] tbl [4][4] = '{'{IDX_FEED1, FEED1_KEY, IDX_FEED2, 8'h00}, '{IDX_FEED1, FEED1_KEY, IDX_MASK, 8'h01},
      '{IDX_CONTROL, 8'h00, IDX_RELOAD, 8'h00}, '{IDX_STATUS, 8'h00, IDX_FEED2, FEED2_KEY}};
    logic [31:0] d;
    logic [1:0] r;
    int b;
    int n;
    wr(IDX_CFG, 8'h01, r);
    b = rst_seen;
    wr(IDX_CONTROL, 8'h04, r);
    check("staged only", active_ctrl, 8'h00);
    wr(IDX_FEED1, FEED1_KEY, r);
    rd(IDX_COUNT, d, r);
    wr(IDX_FEED2, FEED2_KEY, r);
    check("fed ctrl", active_ctrl, 8'h04);
    check("read between", rst_seen - b, 0);
    while (wdt_reset !== 1'b1) @(posedge ref_clk);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wdt_reset !== 1'b1);
    check("reload period", n, 32);
    wr(IDX_CONTROL, 8'h00, r);
    feed();
    foreach (tbl[i]) begin
      b = rst_seen;
      wr(tbl[i][0], tbl[i][1], r);
      wr(tbl[i][2], tbl[i][3], r);
      repeat (3) @(posedge ref_clk);
      check("bad feed pulses", rst_seen - b, 1);
    end
  endtask : t_watchdog
  task automatic t_safety();
    logic [1:0] r;
    wr(IDX_CFG, 8'h03, r);
    @(posedge ref_clk);
    check("run forced", active_ctrl.run_control, 1'b1);
    check("clk forced", clock_select, 1'b1);
    for (int k = 0; k < 2; k++) begin
      wr(IDX_CONTROL, k ? 8'h40 : 8'h20, r);
      feed();
      check("written once", active_ctrl.prescale_tap, 3'h1);
    end
  endtask : t_safety
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset_bus();
    t_timer();
    t_watchdog();
    t_safety();
    results();
  end
endmodule : test_watchdog_feed_and_control
bind wdfc_watchdog wdfc_chk u_chk (.ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .active_ctrl, .clock_select);
